// >>> src/power_good_startup_sequencer.sv
// Contract
// (RULE_01) no pin function: gate clocks until rails
// (RULE_02) output rails ramp within 4ms of core
// (RULE_03) rail valid once above 1.62V
// (RULE_04) pin low halts start-up until high
// (RULE_05) supervisor holds pin low from power-up
// (RULE_06) sleep mode: first rise loads selected config
// (RULE_07) sleep mode: later rises restore loaded config
// (RULE_08) sleep mode: pin low enters low power
// (RULE_09) wake resumes previous operating state
// (RULE_10) reboot mode: pin low resets device
// (RULE_11) reboot mode: release loads fresh config
// (RULE_12) pin low hold after last output rail
// (RULE_13) configuration enables at most one function
// (RULE_14) pin function tolerates long output-rail delay
// (RULE_15) core rails before or with output rails
// (RULE_16) hold time is 200 microseconds
// (RULE_17) synchronise and deglitch the pin
`timescale 1ns/1ps
module power_good_startup_sequencer
    import pwr_seq_pkg::*;
#(
    parameter int FILTER_LEN = FILTER_CYC
) (
    input wire logic mclk,
    input wire logic reset,
    pwr_seq_if.device link,
    input wire logic sleep_fn_en,
    input wire logic reboot_fn_en,
    input wire logic [CFG_SEL_W-1:0] cfg_select,
    output logic clocks_enabled,
    output logic pll_enabled,
    output logic core_reset,
    output logic [CFG_SEL_W-1:0] active_cfg,
    output logic cfg_load_pulse,
    output logic sleeping,
    output logic cfg_fault
);
    ////////////////////////////////////////////////////////////////
    // two-flop synchronisers for every level from outside
    typedef struct packed {
        logic pin;
        logic core;
        logic out;
        logic sleep_en;
        logic reboot_en;
        logic [CFG_SEL_W-1:0] sel;
    } async_t;
    async_t async_in;
    async_t sync_a;
    async_t sync_b;
    assign async_in = '{
        pin: link.supply_ok_pin,
        core: link.core_rail_ok,
        out: link.output_rail_ok,
        sleep_en: sleep_fn_en,
        reboot_en: reboot_fn_en,
        sel: cfg_select
    };
    always_ff @(posedge mclk) begin
        if (reset) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= async_in;
            sync_b <= sync_a; // [RULE_17]
        end
    end
    logic core_ok;
    logic out_ok;
    assign core_ok = sync_b.core; // [RULE_03]
    assign out_ok = sync_b.out; // [RULE_03]

    ////////////////////////////////////////////////////////////////
    // selection word taken only after standing still one cycle,
    // so bits that crossed on different edges never mix
    logic [CFG_SEL_W-1:0] cfg_prev;
    logic cfg_steady;
    always_ff @(posedge mclk) begin
        if (reset) begin
            cfg_prev <= '0;
        end else begin
            cfg_prev <= sync_b.sel;
        end
    end
    assign cfg_steady = (cfg_prev == sync_b.sel);

    ////////////////////////////////////////////////////////////////
    // glitch filter on the pin
    logic pin_level;
    logic [$clog2(FILTER_LEN+1)-1:0] filt_cnt;
    always_ff @(posedge mclk) begin
        if (reset) begin
            pin_level <= 1'b0;
            filt_cnt <= '0;
        end else if (sync_b.pin == pin_level) begin
            filt_cnt <= '0;
        end else if (filt_cnt == ($clog2(FILTER_LEN+1))'(FILTER_LEN - 1)) begin
            pin_level <= sync_b.pin; // [RULE_17]
            filt_cnt <= '0;
        end else begin
            filt_cnt <= filt_cnt + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // function select; both set is refused
    pin_fn_t fn;
    always_comb begin
        if (sync_b.sleep_en && !sync_b.reboot_en) begin
            fn = PIN_FN_SLEEP;
        end else if (sync_b.reboot_en && !sync_b.sleep_en) begin
            fn = PIN_FN_REBOOT;
        end else begin
            fn = PIN_FN_NONE; // [RULE_13]
        end
    end

    ////////////////////////////////////////////////////////////////
    // start-up state machine
    seq_state_t state;
    logic loaded;
    logic fresh_load;
    logic load_done;
    // sleep mode restores the kept word instead of loading anew
    assign fresh_load = (state == ST_LOAD) && !(fn == PIN_FN_SLEEP && loaded); // [RULE_07]
    // a fresh load waits for a steady selection word
    assign load_done = (state == ST_LOAD) && (!fresh_load || cfg_steady);
    always_ff @(posedge mclk) begin
        if (reset) begin
            state <= ST_WAIT_CORE;
        end else begin
            case (state)
                ST_WAIT_CORE: begin
                    if (core_ok) begin
                        state <= ST_WAIT_PIN;
                    end
                end
                ST_WAIT_PIN: begin
                    if (!core_ok) begin
                        state <= ST_WAIT_CORE;
                    end else if (fn == PIN_FN_NONE) begin
                        if (out_ok) begin
                            state <= ST_LOAD; // [RULE_01]
                        end
                    end else if (pin_level) begin
                        state <= ST_LOAD; // [RULE_04] [RULE_14]
                    end
                end
                ST_LOAD: begin
                    if (load_done) begin
                        state <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (!core_ok) begin
                        state <= ST_WAIT_CORE;
                    end else if (fn == PIN_FN_SLEEP && !pin_level) begin
                        state <= ST_SLEEP; // [RULE_08]
                    end else if (fn == PIN_FN_REBOOT && !pin_level) begin
                        state <= ST_WAIT_PIN; // [RULE_10]
                    end
                end
                ST_SLEEP: begin
                    if (!core_ok) begin
                        state <= ST_WAIT_CORE;
                    end else if (pin_level || fn != PIN_FN_SLEEP) begin
                        state <= ST_RUN; // [RULE_09]
                    end
                end
                default: begin
                    state <= ST_WAIT_CORE;
                end
            endcase
        end
    end

    // loaded flag: set by a finished load, cleared by core loss or restart
    always_ff @(posedge mclk) begin
        if (reset) begin
            loaded <= 1'b0;
        end else if (load_done) begin
            loaded <= 1'b1; // [RULE_07]
        end else if (!core_ok || (state == ST_RUN && fn == PIN_FN_REBOOT && !pin_level)) begin
            loaded <= 1'b0; // [RULE_10]
        end
    end

    // latched selection word and its load strobe
    always_ff @(posedge mclk) begin
        if (reset) begin
            active_cfg <= '0;
            cfg_load_pulse <= 1'b0;
        end else if (fresh_load && cfg_steady) begin
            active_cfg <= sync_b.sel; // [RULE_06] [RULE_11]
            cfg_load_pulse <= 1'b1;
        end else begin
            cfg_load_pulse <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // registered outputs
    always_ff @(posedge mclk) begin
        if (reset) begin
            clocks_enabled <= 1'b0;
            pll_enabled <= 1'b0;
            core_reset <= 1'b1;
            sleeping <= 1'b0;
            cfg_fault <= 1'b0;
        end else begin
            clocks_enabled <= (state == ST_RUN) && out_ok; // [RULE_01]
            pll_enabled <= (state == ST_RUN) || (state == ST_LOAD); // [RULE_08]
            core_reset <= (state == ST_WAIT_CORE) || (state == ST_WAIT_PIN); // [RULE_10]
            sleeping <= (state == ST_SLEEP);
            cfg_fault <= sync_b.sleep_en && sync_b.reboot_en; // [RULE_13]
        end
    end
endmodule : power_good_startup_sequencer

// >>> src/power_supervisor.sv
`timescale 1ns/1ps
module power_supervisor
    import pwr_seq_pkg::*;
#(
    parameter int HOLD_CYC = PIN_HOLD_CYC,
    parameter int RAIL_DLY_CYC = OUT_RAIL_DELAY_CYC
) (
    input wire logic mclk,
    input wire logic reset,
    pwr_seq_if.supervisor link,
    input wire logic core_rail_up,
    input wire logic output_rail_up,
    input wire logic request_down,
    output logic rail_delay_late
);
    sup_state_t st;
    logic [$clog2(HOLD_CYC+1)-1:0] hold_cnt;
    logic [$clog2(RAIL_DLY_CYC+1)-1:0] dly_cnt;
    always_ff @(posedge mclk) begin
        if (reset) begin
            link.core_rail_ok <= 1'b0;
            link.output_rail_ok <= 1'b0;
        end else begin
            link.core_rail_ok <= core_rail_up;
            link.output_rail_ok <= output_rail_up && core_rail_up; // [RULE_15]
        end
    end
    always_ff @(posedge mclk) begin
        if (reset) begin
            st <= SV_LOW;
            hold_cnt <= '0;
            link.supply_ok_pin <= 1'b0; // [RULE_05]
        end else begin
            case (st)
                SV_LOW: begin
                    link.supply_ok_pin <= 1'b0;
                    hold_cnt <= '0;
                    if (link.core_rail_ok && link.output_rail_ok && !request_down) begin
                        st <= SV_HOLD;
                    end
                end
                SV_HOLD: begin
                    if (!(link.core_rail_ok && link.output_rail_ok) || request_down) begin
                        st <= SV_LOW;
                    end else if (hold_cnt == ($clog2(HOLD_CYC+1))'(HOLD_CYC - 1)) begin
                        st <= SV_HIGH; // [RULE_12] [RULE_16]
                        link.supply_ok_pin <= 1'b1;
                    end else begin
                        hold_cnt <= hold_cnt + 1'b1;
                    end
                end
                SV_HIGH: begin
                    if (!(link.core_rail_ok && link.output_rail_ok) || request_down) begin
                        st <= SV_LOW;
                        link.supply_ok_pin <= 1'b0;
                    end
                end
                default: begin
                    st <= SV_LOW;
                end
            endcase
        end
    end
    // flags output rail later than the delay bound after core
    always_ff @(posedge mclk) begin
        if (reset) begin
            dly_cnt <= '0;
            rail_delay_late <= 1'b0;
        end else if (!link.core_rail_ok || link.output_rail_ok) begin
            dly_cnt <= '0;
        end else if (dly_cnt == ($clog2(RAIL_DLY_CYC+1))'(RAIL_DLY_CYC)) begin
            rail_delay_late <= 1'b1; // [RULE_02]
        end else begin
            dly_cnt <= dly_cnt + 1'b1;
        end
    end
endmodule : power_supervisor

// >>> src/pwr_seq_if.sv
`timescale 1ns/1ps
interface pwr_seq_if;
    logic supply_ok_pin;
    logic core_rail_ok;
    logic output_rail_ok;
    modport device (input supply_ok_pin, input core_rail_ok, input output_rail_ok);
    modport supervisor (output supply_ok_pin, output core_rail_ok, output output_rail_ok);
endinterface : pwr_seq_if

// >>> src/pwr_seq_pkg.sv
package pwr_seq_pkg;
    // pin function chosen by the sleep and reboot enable inputs
    typedef enum logic [1:0] {
        PIN_FN_NONE = 2'h0,
        PIN_FN_SLEEP = 2'h1,
        PIN_FN_REBOOT = 2'h2
    } pin_fn_t;
    // device start-up states, gray along start-up path
    typedef enum logic [2:0] {
        ST_WAIT_CORE = 3'h0,
        ST_WAIT_PIN = 3'h1,
        ST_LOAD = 3'h3,
        ST_RUN = 3'h2,
        ST_SLEEP = 3'h6
    } seq_state_t;
    // supervisor states
    typedef enum logic [1:0] {
        SV_LOW = 2'h0,
        SV_HOLD = 2'h1,
        SV_HIGH = 2'h3
    } sup_state_t;
    localparam int CLK_HZ = 25_000_000;
    localparam int OUT_RAIL_DELAY_US = 4000;
    localparam int OUT_RAIL_DELAY_CYC = (OUT_RAIL_DELAY_US * (CLK_HZ / 1_000_000));
    localparam int PIN_HOLD_US = 200;
    localparam int PIN_HOLD_CYC = (PIN_HOLD_US * (CLK_HZ / 1_000_000));
    localparam int FILTER_CYC = 4;
    localparam int CFG_SEL_W = 5;
    localparam int CFG_W = 8;
    localparam int RAIL_MV = 1620;
endpackage : pwr_seq_pkg

// >>> tb/pwr_seq_checker.sv
`timescale 1ns/1ps
module pwr_seq_checker #(
    parameter int HOLD_CYC = 20
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic supply_ok_pin,
    input wire logic core_rail_ok,
    input wire logic output_rail_ok
);
    default clocking cb @(posedge mclk); endclocking
    int hold_cnt;
    // cycles with both rails valid
    always_ff @(posedge mclk) begin
        if (reset || !(core_rail_ok && output_rail_ok)) begin
            hold_cnt <= 0;
        end else if (hold_cnt < 100000) begin
            hold_cnt <= hold_cnt + 1;
        end
    end
    ////////////////////////////////////////////////////////////
    sequence s_rails_up;
        core_rail_ok && output_rail_ok;
    endsequence
    sequence s_pin_gone;
        ##[0:1] !supply_ok_pin;
    endsequence
    property p_low_in_reset;
        reset |=> !supply_ok_pin;
    endproperty
    property p_rails_low;
        reset |=> !core_rail_ok && !output_rail_ok;
    endproperty
    property p_rise_needs_rails;
        disable iff (reset) $rose(supply_ok_pin) |-> s_rails_up;
    endproperty
    property p_hold_before_rise;
        disable iff (reset) $rose(supply_ok_pin) |-> hold_cnt >= HOLD_CYC - 1;
    endproperty
    property p_out_long_up;
        disable iff (reset) $rose(supply_ok_pin) |-> $past(output_rail_ok, 8);
    endproperty
    property p_fall_out;
        disable iff (reset) $fell(output_rail_ok) |-> s_pin_gone;
    endproperty
    property p_fall_core;
        disable iff (reset) $fell(core_rail_ok) |-> s_pin_gone;
    endproperty
    property p_core_first;
        disable iff (reset) $rose(output_rail_ok) |-> core_rail_ok;
    endproperty
    a_low_in_reset: assert property (p_low_in_reset) else $error("pin high after reset");
    a_rails_low: assert property (p_rails_low) else $error("rail flag high after reset");
    a_rise_needs_rails: assert property (p_rise_needs_rails) else $error("pin rose without rails");
    a_hold_before_rise: assert property (p_hold_before_rise) else $error("pin rose before hold");
    a_out_long_up: assert property (p_out_long_up) else $error("output rail too recent");
    a_fall_out: assert property (p_fall_out) else $error("pin kept after output loss");
    a_fall_core: assert property (p_fall_core) else $error("pin kept after core loss");
    a_core_first: assert property (p_core_first) else $error("output rail before core");
endmodule : pwr_seq_checker

// >>> tb/test_power_good_startup_sequencer.sv
`timescale 1ns/1ps
module test_power_good_startup_sequencer;
    import pwr_seq_pkg::*;
    localparam int HOLD = 20;
    logic mclk = 0, reset = 1, core_rail_up = 0, output_rail_up = 0, request_down = 0;
    logic sleep_fn_en = 0, reboot_fn_en = 0;
    logic [CFG_SEL_W-1:0] cfg_select = 5'h00, active_cfg;
    logic clocks_enabled, pll_enabled, core_reset, cfg_load_pulse, sleeping, cfg_fault, rail_delay_late;
    int errors = 0, cmp_count = 0, pulses = 0, n;
    pwr_seq_if link();
    power_good_startup_sequencer #(.FILTER_LEN(4)) power_good_startup_sequencer_i (.mclk(mclk), .reset(reset),
        .link(link), .sleep_fn_en(sleep_fn_en), .reboot_fn_en(reboot_fn_en), .cfg_select(cfg_select),
        .clocks_enabled(clocks_enabled), .pll_enabled(pll_enabled), .core_reset(core_reset),
        .active_cfg(active_cfg), .cfg_load_pulse(cfg_load_pulse), .sleeping(sleeping), .cfg_fault(cfg_fault));
    power_supervisor #(.HOLD_CYC(HOLD), .RAIL_DLY_CYC(50)) power_supervisor_i (.mclk(mclk), .reset(reset),
        .link(link), .core_rail_up(core_rail_up), .output_rail_up(output_rail_up),
        .request_down(request_down), .rail_delay_late(rail_delay_late));
    pwr_seq_checker #(.HOLD_CYC(HOLD)) pwr_seq_checker_i (.mclk(mclk), .reset(reset),
        .supply_ok_pin(link.supply_ok_pin), .core_rail_ok(link.core_rail_ok), .output_rail_ok(link.output_rail_ok));
    initial forever #20 mclk = ~mclk;
    always @(posedge mclk) begin if (cfg_load_pulse === 1'b1) pulses++; end
    ////////////////////////////////////////////////////////////
    task finish_test;
        $display("errors=%0d compares=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    task check(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1) begin errors++; $display("mismatch at %0t: %s", $time, msg); end
    endtask : check
    task cycles(input int k);
        repeat (k) @(negedge mclk);
    endtask : cycles
    task wait_on(input int sel, input string msg);
        logic hit;
        for (int i = 0; i < 400; i++) begin
            @(negedge mclk);
            case (sel)
                0: hit = cfg_load_pulse;
                1: hit = clocks_enabled;
                2: hit = sleeping;
                3: hit = !sleeping;
                4: hit = core_reset;
                default: hit = !clocks_enabled;
            endcase
            if (hit === 1'b1) return;
        end
        errors++;
        $display("mismatch at %0t: timeout %s", $time, msg);
        finish_test();
    endtask : wait_on
    task start(input logic slp, input logic rbt, input logic [CFG_SEL_W-1:0] sel);
        {reset, core_rail_up, output_rail_up, request_down} = 4'h8;
        {sleep_fn_en, reboot_fn_en, cfg_select} = {slp, rbt, sel};
        cycles(2);
        reset = 0;
    endtask : start
    ////////////////////////////////////////////////////////////
    task t_none;
        start(0, 0, 5'h01);
        core_rail_up = 1;
        cycles(30);
        check(clocks_enabled === 1'b0, "clocks before output rail");
        output_rail_up = 1;
        wait_on(1, "clocks on");
        check(rail_delay_late === 1'b0, "late flag set");
        cycles(HOLD + 10);
        check(link.supply_ok_pin === 1'b1, "pin not high");
        output_rail_up = 0;
        wait_on(5, "clocks off");
        core_rail_up = 0;
        cycles(4);
        check(link.supply_ok_pin === 1'b0, "pin after rail loss");
    endtask : t_none
    task t_sleep;
        start(1, 0, 5'h0A);
        core_rail_up = 1;
        cycles(60);
        check(rail_delay_late === 1'b1, "late flag clear");
        output_rail_up = 1;
        cycles(HOLD / 2);
        check(active_cfg === 5'h00 && clocks_enabled === 1'b0, "started with pin low");
        wait_on(0, "first load");
        check(active_cfg === 5'h0A, "loaded config");
        wait_on(1, "clocks on");
        cfg_select = 5'h15;
        request_down = 1;
        wait_on(2, "sleep");
        check(pll_enabled === 1'b0 && clocks_enabled === 1'b0, "still powered");
        n = pulses;
        request_down = 0;
        wait_on(3, "wake");
        wait_on(1, "clocks back");
        check(pulses == n && active_cfg === 5'h0A, "config not restored");
    endtask : t_sleep
    task t_reboot;
        start(0, 1, 5'h03);
        core_rail_up = 1;
        output_rail_up = 1;
        wait_on(0, "load");
        check(active_cfg === 5'h03, "first config");
        wait_on(1, "clocks on");
        cfg_select = 5'h1C;
        request_down = 1;
        wait_on(4, "restart");
        check(clocks_enabled === 1'b0, "clocks during restart");
        request_down = 0;
        wait_on(0, "fresh load");
        check(active_cfg === 5'h1C, "fresh config");
    endtask : t_reboot
    task t_both;
        start(1, 1, 5'h07);
        core_rail_up = 1;
        output_rail_up = 1;
        cycles(HOLD + 30);
        check(cfg_fault === 1'b1 && sleeping === 1'b0, "both functions taken");
    endtask : t_both
    initial begin
        t_none();
        t_sleep();
        t_reboot();
        t_both();
        finish_test();
    end
endmodule : test_power_good_startup_sequencer
